// ==== inc/pbm_defs.svh ====
// Constants for the protection bit map decoder.
//
// Contract
// - A start field of zero means lock bit zero itself, not an adder.
// - A nonzero start field is adder c; bit is two to m, plus one, plus c.
// - Sector lock bits rise by one from first to last bit of a section.
// - The end field is an adder on the same base, giving the last bit; the bottom 8K blocks use bits up to two above it.
// - Upward: four 8K, one 32K, density count of 64K, one 32K, four 8K.
// - Sector type 2 is 8 Kbyte, type 3 is 32 Kbyte, type 4 is 64 Kbyte.
// - 8K and 32K sections hold two to the power n sectors, n a byte.
// - The 64K section holds two to the power m, minus two, blocks.
// - Density constant m is 4, 5, 6, 7, 8 for 8 to 128 Mbit parts.
// - Adder fields are signed two's complement bytes; zero means bit zero.
// - Bottom 8K section: start adder FFh (minus one), end adder printed 04h.
// - Lower 32K section: start and end both use adder FDh (minus three).
// - 64K section: start is bit zero, end adder FCh (minus four).
// - Upper 32K section: start and end both use adder FEh (minus two).
// - Top 8K section: start adder 07h, end adder 0Eh.
// - In 8K sections odd bits are read locks, even bits write locks.
// - 4 Kbyte erase sectors form no section; only locked blocks are listed.
`ifndef PBM_DEFS_SVH
`define PBM_DEFS_SVH

`define PBM_SECTIONS 5
`define PBM_ADDR_W 24
`define PBM_BIT_W 9

`define PBM_TYPE_8K 8'h02
`define PBM_TYPE_32K 8'h03
`define PBM_TYPE_64K 8'h04
`define PBM_SHIFT_8K 5'h0D
`define PBM_SHIFT_32K 5'h0F
`define PBM_SHIFT_64K 5'h10

`define PBM_M_MIN 4'h4
`define PBM_M_MAX 4'h8
`define PBM_M_DEFAULT 4'h6

`define PBM_S1_TYPE 8'h02
`define PBM_S1_NEXP 8'h02
`define PBM_S1_START 8'hFF
`define PBM_S1_END 8'h04
`define PBM_S2_TYPE 8'h03
`define PBM_S2_NEXP 8'h00
`define PBM_S2_START 8'hFD
`define PBM_S2_END 8'hFD
`define PBM_S3_TYPE 8'h04
`define PBM_S3_NEXP 8'h00
`define PBM_S3_START 8'h00
`define PBM_S3_END 8'hFC
`define PBM_S4_TYPE 8'h03
`define PBM_S4_NEXP 8'h00
`define PBM_S4_START 8'hFE
`define PBM_S4_END 8'hFE
`define PBM_S5_TYPE 8'h02
`define PBM_S5_NEXP 8'h02
`define PBM_S5_START 8'h07
`define PBM_S5_END 8'h0E

`endif

// ==== inc/pbm_pkg.sv ====
// Types shared by the protection bit map decoder and its bench.
`include "pbm_defs.svh"

package pbm_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] sector_type;
    logic [7:0] count_exp;
    logic [7:0] first_adder;
    logic [7:0] last_adder;
  } pbm_section_t;

  typedef struct packed {
    logic [`PBM_ADDR_W-1:0] addr;
    logic [3:0] density_m;
  } pbm_req_t;

  typedef struct packed {
    logic in_range;
    logic [2:0] section;
    logic [7:0] sector_type;
    logic [`PBM_BIT_W-1:0] write_lock_bit;
    logic [`PBM_BIT_W-1:0] read_lock_bit;
    logic has_read_lock;
    logic [`PBM_BIT_W-1:0] section_first_lock_bit;
    logic [`PBM_BIT_W-1:0] section_last_lock_bit;
  } pbm_rsp_t;

endpackage : pbm_pkg

// ==== tb/pbm_host.sv ====
// Host model that issues lookups to the decoder.
module pbm_host (
  // Clock.
  input wire logic clk,
  // Lookup request.
  output logic req_valid,
  output pbm_pkg::pbm_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  import pbm_pkg::*;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // The request is scrambled once dropped so that stale data never helps.
  task automatic ask(logic [23:0] a, logic [3:0] m);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: a, density_m: m};
    @(posedge clk);
    req_valid <= 1'b0;
    req <= ~req;
  endtask : ask
endmodule : pbm_host

// ==== tb/pbm_properties.sv ====
// Concurrent checks on the decoder lookup ports.
module pbm_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Lookup request and answer.
  input wire logic req_valid,
  input wire pbm_pkg::pbm_req_t req,
  input wire logic rsp_valid,
  input wire pbm_pkg::pbm_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import pbm_pkg::*;
  logic [7:0] blk;
  logic [3:0] dm;
  assign blk = req.addr[23:16];
  assign dm = req.density_m;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_lat; rsp_valid == $past(req_valid); endproperty
  a_lat: assert property (p_lat) else $error("late answer");
  property p_hold; !req_valid |=> $stable(rsp); endproperty
  a_hold: assert property (p_hold) else $error("answer moved");
  property p_rl; rsp_valid && rsp.has_read_lock |-> !rsp.write_lock_bit[0]
    && rsp.read_lock_bit == rsp.write_lock_bit + 9'h001
    && rsp.sector_type == 8'h02; endproperty
  a_rl: assert property (p_rl) else $error("lock pair");
  property p_32; rsp_valid && rsp.sector_type == 8'h03 |->
    rsp.section_first_lock_bit == rsp.section_last_lock_bit; endproperty
  a_32: assert property (p_32) else $error("32K bits");
  property p_64; rsp_valid && rsp.section == 3'h2 |-> rsp.sector_type ==
    8'h04 && rsp.write_lock_bit == 9'($past(blk) - 8'h01)
    && rsp.section_first_lock_bit == 9'h000; endproperty
  a_64: assert property (p_64) else $error("64K bit");
  property p_top; rsp_valid && rsp.section == 3'h4 |->
    rsp.section_last_lock_bit == rsp.section_first_lock_bit + 9'h007;
  endproperty
  a_top: assert property (p_top) else $error("top span");
  property p_out; rsp_valid && !rsp.in_range |-> rsp == '0; endproperty
  a_out: assert property (p_out) else $error("out fields");
  property p_m; rsp_valid && rsp.in_range |->
    $past(dm) inside {[4'h4:4'h8]}; endproperty
  a_m: assert property (p_m) else $error("bad density");
endmodule : pbm_properties

bind pbm_decoder pbm_properties u_props (.clk, .rst_b, .req_valid, .req,
  .rsp_valid, .rsp);

// ==== tb/tb.sv ====
// Bench that walks the lock bit map over every density.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbm_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid;
  pbm_req_t req;
  logic rsp_valid;
  pbm_rsp_t rsp;
  int fails = 0;
  int n_tests = 0;
  int b;
  initial begin
    forever #5 clk = ~clk;
  end
  pbm_host host (.clk(clk), .req_valid(req_valid), .req(req));
  pbm_decoder uut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  task automatic look(int a, int m, int s, int w, int r, int f, int l);
    logic [7:0] ty;
    logic pr;
    ty = (s == 2) ? 8'h04 : ((s == 1 || s == 3) ? 8'h03 : 8'h02);
    pr = (s == 0 || s == 4);
    host.ask(24'(a), 4'(m));
    #1;
    n_tests++;
    if (rsp_valid !== 1'b1 || rsp.in_range !== (s < 5) ||
      (s < 5 && (rsp.section !== 3'(s) || rsp.write_lock_bit !== 9'(w) ||
      rsp.read_lock_bit !== 9'(r) || rsp.section_first_lock_bit !== 9'(f)
      || rsp.section_last_lock_bit !== 9'(l) ||
      rsp.sector_type !== ty || rsp.has_read_lock !== pr))) begin
      $display("mismatch at %0t: addr %h m %0d", $time, a, m);
      fails++;
    end
  endtask : look
  task automatic t_ends;
    for (int m = 4; m <= 8; m++) begin
      b = 1 << m;
      for (int k = 0; k < 4; k++) begin
        look(k * 'h2000, m, 0, b + 2 * k, b + 2 * k + 1, b, b + 5);
        look(b * 'h10000 - 'h8000 + k * 'h2000, m, 4, b + 8 + 2 * k,
          b + 9 + 2 * k, b + 8, b + 15);
      end
    end
    $display("ends done");
  endtask : t_ends
  task automatic t_middle;
    for (int m = 4; m <= 8; m++) begin
      b = 1 << m;
      look('h8000, m, 1, b - 2, b - 2, b - 2, b - 2);
      look('h10000, m, 2, 0, 0, 0, b - 3);
      look((b - 2) * 'h10000, m, 2, b - 3, b - 3, 0, b - 3);
      look((b - 1) * 'h10000, m, 3, b - 1, b - 1, b - 1, b - 1);
    end
    $display("middle done");
  endtask : t_middle
  task automatic t_bad;
    look(0, 3, 5, 0, 0, 0, 0);
    look(0, 9, 5, 0, 0, 0, 0);
    look('h100000, 4, 5, 0, 0, 0, 0);
    $display("bad done");
  endtask : t_bad
  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_ends();
    t_middle();
    t_bad();
    conclude();
  end
  initial begin
    #20000;
    fails++;
    conclude();
  end
endmodule : tb

// ==== verilog/pbm_decoder.sv ====
// Maps a flash address to the index of its block protection lock bits.
`include "pbm_defs.svh"

module pbm_decoder (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Lookup request.
  input wire logic req_valid,
  input wire pbm_pkg::pbm_req_t req,
  // Lookup answer.
  output logic rsp_valid,
  output pbm_pkg::pbm_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import pbm_pkg::*;

  // Section descriptors as a part would publish them, bottom upward.
  localparam pbm_section_t SECT [`PBM_SECTIONS] = '{
    '{`PBM_S1_TYPE, `PBM_S1_NEXP, `PBM_S1_START, `PBM_S1_END},
    '{`PBM_S2_TYPE, `PBM_S2_NEXP, `PBM_S2_START, `PBM_S2_END},
    '{`PBM_S3_TYPE, `PBM_S3_NEXP, `PBM_S3_START, `PBM_S3_END},
    '{`PBM_S4_TYPE, `PBM_S4_NEXP, `PBM_S4_START, `PBM_S4_END},
    '{`PBM_S5_TYPE, `PBM_S5_NEXP, `PBM_S5_START, `PBM_S5_END}
  };

  // Turns a start or end field into a lock bit index.
  function automatic logic [`PBM_BIT_W-1:0] adder_to_bit(
    input logic [3:0] m,
    input logic [7:0] c
  );
    int v;
    v = 0;
    if (c == 8'h00) begin
      v = 0;
    end else begin
      v = (32'sh1 <<< m) + 32'sh1 + int'($signed(c));
    end
    return v[`PBM_BIT_W-1:0];
  endfunction : adder_to_bit

  // Log2 of the block size for a sector type; zero for unknown types.
  function automatic logic [4:0] type_shift(input logic [7:0] t);
    logic [4:0] s;
    s = 5'h00;
    case (t)
      `PBM_TYPE_8K: s = `PBM_SHIFT_8K;
      `PBM_TYPE_32K: s = `PBM_SHIFT_32K;
      `PBM_TYPE_64K: s = `PBM_SHIFT_64K;
      default: s = 5'h00;
    endcase
    return s;
  endfunction : type_shift

  // Number of blocks in a section.
  function automatic logic [31:0] sect_count(
    input pbm_section_t s,
    input logic [3:0] m
  );
    logic [31:0] n;
    n = 32'h0;
    if (s.sector_type == `PBM_TYPE_64K) begin
      n = (32'h1 << m) - 32'h2;
    end else if (s.count_exp < 8'h20) begin
      n = 32'h1 << s.count_exp;
    end else begin
      n = 32'h0;
    end
    return n;
  endfunction : sect_count

  // True when the density constant is one that the map knows.
  function automatic logic density_ok(input logic [3:0] m);
    logic ok;
    ok = (m >= `PBM_M_MIN) && (m <= `PBM_M_MAX);
    return ok;
  endfunction : density_ok

  // Only the 8 Kbyte blocks carry a read lock beside their write lock.
  function automatic logic has_pair(input logic [7:0] t);
    logic p;
    p = (t == `PBM_TYPE_8K);
    return p;
  endfunction : has_pair

  // Block index of an address inside a section that starts at base.
  function automatic logic [31:0] block_offset(
    input logic [31:0] a,
    input logic [31:0] base,
    input logic [4:0] sh
  );
    logic [31:0] off;
    off = (a - base) >> sh;
    return off;
  endfunction : block_offset

  // Write lock bit of a block; paired blocks take two bits each.
  function automatic logic [`PBM_BIT_W-1:0] write_bit(
    input logic [`PBM_BIT_W-1:0] first,
    input logic [31:0] off,
    input logic paired
  );
    logic [31:0] step;
    step = paired ? (off << 1) : off;
    return first + step[`PBM_BIT_W-1:0];
  endfunction : write_bit

  // Read lock bit: the odd bit after the even write bit of a paired block, else the write bit.
  function automatic logic [`PBM_BIT_W-1:0] read_bit(
    input logic [`PBM_BIT_W-1:0] wbit,
    input logic paired
  );
    logic [`PBM_BIT_W-1:0] rbit;
    rbit = wbit + {{(`PBM_BIT_W-1){1'b0}}, paired};
    return rbit;
  endfunction : read_bit

  // Request address widened to the arithmetic width of the map.
  logic [31:0] req_addr;
  logic density_good;

  assign req_addr = {{(32-`PBM_ADDR_W){1'b0}}, req.addr};
  assign density_good = density_ok(req.density_m);

  // Per-section view of the map for the density of the current request.
  logic [4:0] sect_shift [`PBM_SECTIONS];
  logic [31:0] sect_size [`PBM_SECTIONS];
  logic [31:0] sect_base [`PBM_SECTIONS];
  logic [`PBM_BIT_W-1:0] sect_first [`PBM_SECTIONS];
  logic [`PBM_BIT_W-1:0] sect_last [`PBM_SECTIONS];
  logic [`PBM_SECTIONS-1:0] sect_hit;

  // Block size and byte count of every section.
  always_comb begin
    for (int i = 0; i < `PBM_SECTIONS; i++) begin
      sect_shift[i] = type_shift(SECT[i].sector_type);
      sect_size[i] = sect_count(SECT[i], req.density_m) << sect_shift[i];
    end
  end

  // Sections sit back to back from address zero upward.
  always_comb begin
    logic [31:0] acc;
    acc = 32'h0;
    for (int i = 0; i < `PBM_SECTIONS; i++) begin
      sect_base[i] = acc;
      acc = acc + sect_size[i];
    end
  end

  // First and last lock bit of every section.
  always_comb begin
    for (int i = 0; i < `PBM_SECTIONS; i++) begin
      sect_first[i] = adder_to_bit(req.density_m, SECT[i].first_adder);
      sect_last[i] = adder_to_bit(req.density_m, SECT[i].last_adder);
    end
  end

  // A section claims the address when the density is known and the address lies inside its byte bounds.
  always_comb begin
    for (int i = 0; i < `PBM_SECTIONS; i++) begin
      sect_hit[i] = density_good && (req_addr >= sect_base[i]) &&
        (req_addr < sect_base[i] + sect_size[i]);
    end
  end

  // The claiming section; bounds never overlap, so at most one claims.
  logic hit_found;
  logic [2:0] hit_idx;

  always_comb begin
    hit_found = 1'b0;
    hit_idx = 3'h0;
    for (int i = 0; i < `PBM_SECTIONS; i++) begin
      if (sect_hit[i]) begin
        hit_found = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  // Lock bits of the claimed block. In the bottom 8 Kbyte section the
  // block bits run two above the end field, which is kept as published.
  logic [7:0] hit_type;
  logic hit_pair;
  logic [31:0] hit_off;
  logic [`PBM_BIT_W-1:0] hit_write;
  logic [`PBM_BIT_W-1:0] hit_read;

  always_comb begin
    hit_type = SECT[hit_idx].sector_type;
    hit_pair = has_pair(hit_type);
    hit_off = block_offset(req_addr, sect_base[hit_idx],
      sect_shift[hit_idx]);
    hit_write = write_bit(sect_first[hit_idx], hit_off, hit_pair);
    hit_read = read_bit(hit_write, hit_pair);
  end

  pbm_rsp_t next_rsp;

  // Answer for the current request; all zero when no section claims it.
  always_comb begin
    next_rsp = '0;
    if (hit_found) begin
      next_rsp.in_range = 1'b1;
      next_rsp.section = hit_idx;
      next_rsp.sector_type = hit_type;
      next_rsp.write_lock_bit = hit_write;
      next_rsp.read_lock_bit = hit_read;
      next_rsp.has_read_lock = hit_pair;
      next_rsp.section_first_lock_bit = sect_first[hit_idx];
      next_rsp.section_last_lock_bit = sect_last[hit_idx];
    end
  end

  // Registered answer, kept in one register group for each concern.
  logic ans_in_range;
  logic [2:0] ans_section;
  logic [7:0] ans_type;
  logic [`PBM_BIT_W-1:0] ans_write;
  logic [`PBM_BIT_W-1:0] ans_read;
  logic ans_pair;
  logic [`PBM_BIT_W-1:0] ans_first;
  logic [`PBM_BIT_W-1:0] ans_last;

  // Answer strobe: high for the cycle after each accepted request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
    end
  end

  // Where the address fell; held until the next accepted request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ans_in_range <= 1'b0;
      ans_section <= 3'h0;
      ans_type <= 8'h00;
    end else if (req_valid) begin
      ans_in_range <= next_rsp.in_range;
      ans_section <= next_rsp.section;
      ans_type <= next_rsp.sector_type;
    end
  end

  // Lock bits of the block; held until the next accepted request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ans_write <= '0;
      ans_read <= '0;
      ans_pair <= 1'b0;
    end else if (req_valid) begin
      ans_write <= next_rsp.write_lock_bit;
      ans_read <= next_rsp.read_lock_bit;
      ans_pair <= next_rsp.has_read_lock;
    end
  end

  // Lock bit ends of the section; held until the next accepted request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ans_first <= '0;
      ans_last <= '0;
    end else if (req_valid) begin
      ans_first <= next_rsp.section_first_lock_bit;
      ans_last <= next_rsp.section_last_lock_bit;
    end
  end

  // The answer port shows the registered fields unchanged.
  assign rsp = '{
    in_range: ans_in_range,
    section: ans_section,
    sector_type: ans_type,
    write_lock_bit: ans_write,
    read_lock_bit: ans_read,
    has_read_lock: ans_pair,
    section_first_lock_bit: ans_first,
    section_last_lock_bit: ans_last
  };

endmodule : pbm_decoder
